/* File: dv/mad_seq_model.sv */
// behavioural model of the clause sequencer that issues instruction groups
`timescale 1ns/100ps
`include "mad_defs.svh"

module mad_seq_model (
   input  wire logic                clk_in,
   input  wire logic                rst_in,
   input  wire logic                issue_in,
   input  wire mad_pkg::mad_group_s want_in,
   output mad_pkg::mad_group_s      group_out,
   output logic                     group_valid_out
);
   mad_pkg::mad_group_s clean;

   ////////////////////////////////////////////////////////////////////////
   // program-side slot hygiene
   always_comb begin
      clean = want_in;
      // no dependents in z or w
      for (int i = 2; i < 4; i++) begin
         if (clean.slot[i].second_word[17:7] == `MAD_OP2_PREV ||
             clean.slot[i].second_word[17:7] == `MAD_OP2_PREV_IEEE) begin
            clean.slot[i].second_word = 32'h00000000;
         end
      end
      for (int i = 0; i < 2; i++) begin
         if (clean.slot[i].second_word[17:7] == `MAD_OP2_PREV) begin
            clean.slot[i+2].second_word[31]  = 1'b0;
            clean.slot[i+2].second_word[6:5] = 2'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // launch on the falling edge, garble the bus between groups
   always_ff @(negedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         group_valid_out <= 1'b0;
         group_out       <= '0;
      end else if (issue_in) begin
         group_valid_out <= 1'b1;
         group_out       <= clean;
      end else begin
         group_valid_out <= 1'b0;
         group_out       <= ~group_out;
      end
   end
endmodule : mad_seq_model

/* File: dv/multiply_add_alu_ops_bench.sv */
// self-checking bench for the multiply-add alu group
`timescale 1ns/100ps
`include "mad_defs.svh"

module multiply_add_alu_ops_bench;
   logic                clk_in;
   logic                rst_in;
   logic                issue;
   mad_pkg::mad_group_s want;
   mad_pkg::mad_group_s grp;
   logic                gvalid;
   logic                rvalid;
   mad_pkg::mad_result_s res;
   int                  fails;
   int                  check_count;
   int                  cycles;

   mad_seq_model seq (.clk_in(clk_in), .rst_in(rst_in), .issue_in(issue),
      .want_in(want), .group_out(grp), .group_valid_out(gvalid));
   mad_alu dut (.clk_in(clk_in), .rst_in(rst_in), .group_valid_in(gvalid),
      .group_in(grp), .result_valid_out(rvalid), .result_out(res));

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (fails == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // hang guard, far above the seventy-odd cycles the run needs
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic cmp_word(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_word

   task automatic cmp_flags(input string what, input logic [3:0] exp,
                            input logic [3:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_flags

   function automatic mad_pkg::mad_slot_s s3(input logic [4:0] op,
      input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
      input logic clamp);
      s3             = '0;
      s3.second_word = {clamp, 13'h0, op, 13'h0};
      s3.src0        = a;
      s3.src1        = b;
      s3.src2        = c;
   endfunction : s3

   function automatic mad_pkg::mad_slot_s s2(input logic [10:0] op,
      input logic [31:0] a, input logic [31:0] b);
      s2             = '0;
      s2.second_word = {14'h0, op, 7'h0};
      s2.src0        = a;
      s2.src1        = b;
   endfunction : s2

   // one group through the model; result one cycle later, then held
   task automatic run_group(input mad_pkg::mad_group_s g,
      input logic [3:0][31:0] ev, input logic [3:0] eh);
      int n;
      n = 0;
      @(negedge clk_in);
      issue <= 1'b1;
      want  <= g;
      @(negedge clk_in);
      issue <= 1'b0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (rvalid !== 1'b1 && n < 8);
      cmp_word("latency", 32'd1, n);
      for (int i = 0; i < 4; i++) begin
         cmp_word($sformatf("slot%0d value", i), ev[i], res.value[i]);
      end
      cmp_flags("handled", eh, res.handled);
      cmp_flags("illegal", 4'h0, res.illegal);
      @(posedge clk_in);
      #1;
      cmp_flags("valid pulse", 4'h0, {3'h0, rvalid});
      cmp_word("held x", ev[0], res.value[0]);
   endtask : run_group

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      @(negedge clk_in);
      rst_in <= 1'b1;
      repeat (16) @(negedge clk_in);
      cmp_flags("reset valid", 4'h0, {3'h0, rvalid});
      cmp_flags("reset result", 4'h1, {3'h0, res === '0});
      rst_in <= 1'b0;
   endtask : t_reset

   // scaled and strict three-source forms, 2*3+1 everywhere
   task automatic t_float_forms;
      mad_pkg::mad_group_s g;
      g.slot = {s3(`MAD_OP3_IEEE, 32'h40000000, 32'h40400000, 32'h3f800000,
                   1'b0),
                s3(`MAD_OP3_QUAD, 32'h40000000, 32'h40400000, 32'h3f800000,
                   1'b0),
                s3(`MAD_OP3_DOUBLE, 32'h40000000, 32'h40400000,
                   32'h3f800000, 1'b0),
                s3(`MAD_OP3_HALVE, 32'h40000000, 32'h40400000,
                   32'h3f800000, 1'b0)};
      run_group(g, {32'h40e00000, 32'h41e00000, 32'h41600000, 32'h40600000},
                4'hf);
   endtask : t_float_forms

   // zero times infinity, u24 wrap, opcode 23 in the two-source space
   task automatic t_zero_and_decode;
      mad_pkg::mad_group_s g;
      g.slot = {s2(11'h017, 32'h40000000, 32'h40400000),
                s3(`MAD_OP3_U24, 32'haa000010, 32'h55000020, 32'hffffff00,
                   1'b0),
                s3(`MAD_OP3_DOUBLE, 32'h00000000, 32'h7f800000,
                   32'h3f800000, 1'b0),
                s3(`MAD_OP3_IEEE, 32'h00000000, 32'h7f800000, 32'h3f800000,
                   1'b0)};
      run_group(g, {32'h00000000, 32'h00000100, 32'h40000000, `MAD_FP_NAN},
                4'h7);
   endtask : t_zero_and_decode

   // y adds clamped w raw, x adds halved z
   task automatic t_dependent;
      mad_pkg::mad_group_s g;
      g.slot = {s3(`MAD_OP3_IEEE, 32'h40000000, 32'h40400000, 32'h3f800000,
                   1'b1),
                s3(`MAD_OP3_HALVE, 32'h40000000, 32'h40400000,
                   32'h3f800000, 1'b0),
                s2(`MAD_OP2_PREV_IEEE, 32'h40000000, 32'h40000000),
                s2(`MAD_OP2_PREV, 32'h3f800000, 32'h3f800000)};
      run_group(g, {`MAD_FP_ONE, 32'h40600000, 32'h41300000, 32'h40900000},
                4'hf);
   endtask : t_dependent

   // integer multiplies with sign and ignored top bytes
   task automatic t_integer;
      mad_pkg::mad_group_s g;
      g.slot = {s2(`MAD_OP2_U24_HI, 32'hffffffff, 32'h01ffffff),
                s2(`MAD_OP2_SMUL_LO, 32'hfffffffe, 32'h00000003),
                s2(`MAD_OP2_UMUL_HI, 32'hfffffffe, 32'h00000003),
                s2(`MAD_OP2_SMUL_HI, 32'hfffffffe, 32'h00000003)};
      run_group(g, {32'h0000ffff, 32'hfffffffa, 32'h00000002, 32'hffffffff},
                4'hf);
   endtask : t_integer

   // each op but ieee, smul hi and the dependent forms once in slot x, where the slot checks watch; float forms
   // use one times three plus zero, y adds w through a zero product
   task automatic t_slot_x;
      mad_pkg::mad_group_s g;
      g         = '0;
      g.slot[3] = s3(`MAD_OP3_DOUBLE, `MAD_FP_ONE, 32'h40400000, 32'h0, 1'b0);
      g.slot[1] = s2(`MAD_OP2_PREV_IEEE, 32'h0, 32'h0);
      g.slot[0] = s3(`MAD_OP3_U24, 32'h12000003, 32'h34000005, 32'h00000010,
                     1'b0);
      run_group(g, {32'h40c00000, 32'h0, 32'h40c00000, 32'h0000001f},
                4'hb);
      g.slot[3] = '0;
      g.slot[1] = '0;
      g.slot[0] = s2(`MAD_OP2_UMUL_HI, 32'hfffffffe, 32'h00000003);
      run_group(g, {96'h0, 32'h00000002}, 4'h1);
      g.slot[0] = s2(`MAD_OP2_U24_HI, 32'h80ffffff, 32'h7fffffff);
      run_group(g, {96'h0, 32'h0000ffff}, 4'h1);
      g.slot[0] = s2(`MAD_OP2_SMUL_LO, 32'h00000007, 32'hfffffffd);
      run_group(g, {96'h0, 32'hffffffeb}, 4'h1);
      g.slot[0] = s3(`MAD_OP3_DOUBLE, `MAD_FP_ONE, 32'h40400000, 32'h0, 1'b0);
      run_group(g, {96'h0, 32'h40c00000}, 4'h1);
      g.slot[0] = s3(`MAD_OP3_QUAD, `MAD_FP_ONE, 32'h40400000, 32'h0, 1'b0);
      run_group(g, {96'h0, 32'h41400000}, 4'h1);
      g.slot[0] = s3(`MAD_OP3_HALVE, `MAD_FP_ONE, 32'h40400000, 32'h0, 1'b0);
      run_group(g, {96'h0, 32'h3fc00000}, 4'h1);
   endtask : t_slot_x

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_in      = 1'b1;
      issue       = 1'b0;
      want        = '0;
      fails       = 0;
      check_count = 0;
      cycles      = 0;
      t_reset();
      t_float_forms();
      t_zero_and_decode();
      t_dependent();
      t_integer();
      t_slot_x();
      // second reset in mid-run, then traffic again
      t_reset();
      t_dependent();
      tally_and_finish();
   end
endmodule : multiply_add_alu_ops_bench

/* File: verilog/mad_alu.sv */
// decode and datapath for the multiply-add alu operation group
`timescale 1ns/100ps
`include "mad_defs.svh"

module mad_alu (
   input  wire logic            clk_in,
   input  wire logic            rst_in,
   input  wire logic            group_valid_in,
   input  wire mad_pkg::mad_group_s  group_in,
   output logic                 result_valid_out,
   output mad_pkg::mad_result_s result_out
);

   ////////////////////////////////////////////////////////////////////////
   // float helpers; denormals flush to zero, rounding truncates

   function automatic logic fp_zero(input logic [31:0] a);
      fp_zero = (a[30:23] == 8'h00);
   endfunction : fp_zero

   function automatic logic fp_inf(input logic [31:0] a);
      fp_inf = (a[30:23] == `MAD_FP_EMAX) && (a[22:0] == 23'h0);
   endfunction : fp_inf

   function automatic logic fp_nan(input logic [31:0] a);
      fp_nan = (a[30:23] == `MAD_FP_EMAX) && (a[22:0] != 23'h0);
   endfunction : fp_nan

   function automatic logic [31:0] fp_mul(input logic [31:0] a,
                                          input logic [31:0] b,
                                          input logic        strict);
      logic        sg;
      logic [47:0] pm;
      logic [9:0]  es;
      sg = a[31] ^ b[31];
      pm = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      es = {2'h0, a[30:23]} + {2'h0, b[30:23]} + {9'h0, pm[47]};
      // legacy form: zero times anything, even inf or nan, is zero
      if (!strict && (fp_zero(a) || fp_zero(b)))
         fp_mul = {sg, 31'h0};
      else if (fp_nan(a) || fp_nan(b))
         fp_mul = `MAD_FP_NAN;
      else if (fp_zero(a) || fp_zero(b))
         fp_mul = (fp_inf(a) || fp_inf(b)) ? `MAD_FP_NAN : {sg, 31'h0};
      else if (fp_inf(a) || fp_inf(b) || es >= `MAD_FP_OVF)
         fp_mul = {sg, `MAD_FP_EMAX, 23'h0};
      else if (es <= `MAD_FP_BIAS)
         fp_mul = {sg, 31'h0};
      else begin
         es = es - `MAD_FP_BIAS;
         fp_mul = {sg, es[7:0], pm[47] ? pm[46:24] : pm[45:23]};
      end
   endfunction : fp_mul

   function automatic logic [31:0] fp_add(input logic [31:0] a,
                                          input logic [31:0] b);
      logic [31:0] big;
      logic [31:0] sml;
      logic [7:0]  ed;
      logic [25:0] ms;
      logic [26:0] sum;
      logic [4:0]  lead;
      logic [4:0]  lz;
      logic [25:0] nrm;
      big  = (a[30:0] >= b[30:0]) ? a : b;
      sml  = (a[30:0] >= b[30:0]) ? b : a;
      ed   = big[30:23] - sml[30:23];
      ms   = (ed > 8'd25) ? 26'h0 : ({1'b1, sml[22:0], 2'h0} >> ed);
      sum  = (big[31] == sml[31]) ? {1'b0, 1'b1, big[22:0], 2'h0} + {1'b0, ms}
                                  : {1'b0, 1'b1, big[22:0], 2'h0} - {1'b0, ms};
      lead = 5'h0;
      for (int k = 0; k < 26; k++) begin
         if (sum[k])
            lead = 5'(k);
      end
      lz   = 5'd25 - lead;
      nrm  = sum[25:0] << lz;
      if (fp_nan(a) || fp_nan(b) || (fp_inf(a) && fp_inf(b) && a[31] != b[31]))
         fp_add = `MAD_FP_NAN;
      else if (fp_inf(a))
         fp_add = a;
      else if (fp_inf(b))
         fp_add = b;
      else if (fp_zero(a))
         fp_add = fp_zero(b) ? {a[31] & b[31], 31'h0} : b;
      else if (fp_zero(b))
         fp_add = a;
      else if (sum[26])
         fp_add = (big[30:23] == 8'hfe) ? {big[31], `MAD_FP_EMAX, 23'h0}
                  : {big[31], big[30:23] + 8'h01, sum[25:3]};
      else if (sum[25:0] == 26'h0 || {3'h0, lz} >= big[30:23])
         fp_add = 32'h00000000;
      else
         fp_add = {big[31], big[30:23] - {3'h0, lz}, nrm[24:2]};
   endfunction : fp_add

   // scale by 2, 4 or one half through the exponent
   function automatic logic [31:0] fp_scale(input logic [31:0] a,
                                            input logic [1:0]  sel);
      logic [8:0] e;
      e = {1'b0, a[30:23]};
      fp_scale = a;
      if (!(fp_zero(a) || fp_inf(a) || fp_nan(a))) begin
         case (sel)
            `MAD_OUTPUT_SCALING_X2, `MAD_OUTPUT_SCALING_X4: begin
               e = e + ((sel == `MAD_OUTPUT_SCALING_X2) ? 9'h001 : 9'h002);
               fp_scale = (e >= {1'b0, `MAD_FP_EMAX})
                        ? {a[31], `MAD_FP_EMAX, 23'h0}
                        : {a[31], e[7:0], a[22:0]};
            end
            `MAD_OUTPUT_SCALING_HALF:
               fp_scale = (e <= 9'h001) ? {a[31], 31'h0}
                        : {a[31], a[30:23] - 8'h01, a[22:0]};
            default:
               fp_scale = a;
         endcase
      end
   endfunction : fp_scale

   // nan and negatives go to zero, above one goes to one
   function automatic logic [31:0] fp_clamp(input logic [31:0] a);
      if (fp_nan(a) || a[31])
         fp_clamp = 32'h00000000;
      else if (a[30:0] > `MAD_FP_ONE)
         fp_clamp = `MAD_FP_ONE;
      else
         fp_clamp = a;
   endfunction : fp_clamp

   ////////////////////////////////////////////////////////////////////////
   // decode

   function automatic mad_pkg::mad_op_e decode(input logic [31:0] w1);
      decode = mad_pkg::MAD_OP_NONE;
      if (w1[`MAD_FMT_HI:`MAD_FMT_LO] != 3'h0) begin
         case (w1[`MAD_OP3_HI:`MAD_OP3_LO])
            `MAD_OP3_HALVE:  decode = mad_pkg::MAD_OP_HALVE;
            `MAD_OP3_IEEE:   decode = mad_pkg::MAD_OP_IEEE;
            `MAD_OP3_DOUBLE: decode = mad_pkg::MAD_OP_DOUBLE;
            `MAD_OP3_QUAD:   decode = mad_pkg::MAD_OP_QUAD;
            `MAD_OP3_U24:    decode = mad_pkg::MAD_OP_U24;
            default:         decode = mad_pkg::MAD_OP_NONE;
         endcase
      end else begin
         case (w1[`MAD_OP2_HI:`MAD_OP2_LO])
            `MAD_OP2_PREV:      decode = mad_pkg::MAD_OP_PREV;
            `MAD_OP2_PREV_IEEE: decode = mad_pkg::MAD_OP_PREV_IEEE;
            `MAD_OP2_SMUL_HI:   decode = mad_pkg::MAD_OP_SMUL_HI;
            `MAD_OP2_UMUL_HI:   decode = mad_pkg::MAD_OP_UMUL_HI;
            `MAD_OP2_U24_HI:    decode = mad_pkg::MAD_OP_U24_HI;
            `MAD_OP2_SMUL_LO:   decode = mad_pkg::MAD_OP_SMUL_LO;
            default:            decode = mad_pkg::MAD_OP_NONE;
         endcase
      end
   endfunction : decode

   ////////////////////////////////////////////////////////////////////////
   // raw result before output scaling and clamping

   function automatic logic [31:0] exec(input mad_pkg::mad_op_e op,
                                        input logic [31:0] a,
                                        input logic [31:0] b,
                                        input logic [31:0] c,
                                        input logic [31:0] prev);
      logic signed [63:0] sp;
      logic [63:0]        up;
      logic [47:0]        p24;
      sp  = $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
      up  = {32'h0, a} * {32'h0, b};
      // upper byte of the 24-bit operands is ignored
      p24 = a[23:0] * b[23:0];
      case (op)
         mad_pkg::MAD_OP_HALVE:
            exec = fp_scale(fp_add(fp_mul(a, b, 1'b0), c), `MAD_OUTPUT_SCALING_HALF);
         mad_pkg::MAD_OP_IEEE:   exec = fp_add(fp_mul(a, b, 1'b1), c);
         mad_pkg::MAD_OP_DOUBLE:
            exec = fp_scale(fp_add(fp_mul(a, b, 1'b0), c), `MAD_OUTPUT_SCALING_X2);
         mad_pkg::MAD_OP_QUAD:
            exec = fp_scale(fp_add(fp_mul(a, b, 1'b0), c), `MAD_OUTPUT_SCALING_X4);
         mad_pkg::MAD_OP_U24:    exec = p24[31:0] + c;
         mad_pkg::MAD_OP_PREV:   exec = fp_add(fp_mul(a, b, 1'b0), prev);
         mad_pkg::MAD_OP_PREV_IEEE: exec = fp_add(fp_mul(a, b, 1'b1), prev);
         mad_pkg::MAD_OP_SMUL_HI: exec = sp[63:32];
         mad_pkg::MAD_OP_UMUL_HI: exec = up[63:32];
         mad_pkg::MAD_OP_U24_HI:  exec = {16'h0, p24[47:32]};
         mad_pkg::MAD_OP_SMUL_LO: exec = sp[31:0];
         default:                 exec = 32'h00000000;
      endcase
   endfunction : exec

   ////////////////////////////////////////////////////////////////////////
   // per-slot datapath

   mad_pkg::mad_op_e       op   [4];
   logic [3:0][31:0]       raw;
   mad_pkg::mad_result_s   next_result;

   for (genvar i = 0; i < 4; i++) begin : g_slot
      logic [31:0] prev;
      logic [31:0] w1;
      logic        float_op;
      logic        two_src;
      assign w1    = group_in.slot[i].second_word;
      assign op[i] = decode(w1);
      // y reads w, x reads z, same group, unmodified
      if (i == `MAD_SLOT_Y) begin : g_y
         assign prev = raw[`MAD_SLOT_W];
      end else if (i == `MAD_SLOT_X) begin : g_x
         assign prev = raw[`MAD_SLOT_Z];
      end else begin : g_zw
         // w and z have no previous slot; they are what feeds forward
         assign prev = 32'h00000000;
      end
      assign raw[i]   = exec(op[i], group_in.slot[i].src0,
                             group_in.slot[i].src1, group_in.slot[i].src2,
                             prev);
      assign float_op = (op[i] == mad_pkg::MAD_OP_HALVE)
                     || (op[i] == mad_pkg::MAD_OP_IEEE)
                     || (op[i] == mad_pkg::MAD_OP_DOUBLE)
                     || (op[i] == mad_pkg::MAD_OP_QUAD)
                     || (op[i] == mad_pkg::MAD_OP_PREV)
                     || (op[i] == mad_pkg::MAD_OP_PREV_IEEE);
      assign two_src  = (op[i] == mad_pkg::MAD_OP_PREV)
                     || (op[i] == mad_pkg::MAD_OP_PREV_IEEE);
      // scaling and clamping reach only the slot's own writeback
      always_comb begin
         logic [31:0] v;
         v = raw[i];
         if (float_op && two_src)
            v = fp_scale(v, w1[`MAD_OUTPUT_SCALING_HI:`MAD_OUTPUT_SCALING_LO]);
         if (float_op && w1[`MAD_CLAMP_BIT])
            v = fp_clamp(v);
         next_result.value[i]   = v;
         next_result.handled[i] = (op[i] != mad_pkg::MAD_OP_NONE);
         // dependent forms in z or w are flagged, not trusted
         next_result.illegal[i] = two_src && (i >= `MAD_SLOT_Z);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // writeback stage

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         result_valid_out <= 1'b0;
      else
         result_valid_out <= group_valid_in;
   end

   // result holds until the next valid group
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         result_out <= '0;
      else if (group_valid_in)
         result_out <= next_result;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks on slot x and y

   mad_pkg::mad_slot_s sx;
   mad_pkg::mad_slot_s sy;
   logic [63:0]        chk_s64;
   logic [63:0]        chk_u64;
   logic [63:0]        chk_m24;
   logic               x_unit;
   assign sx      = group_in.slot[`MAD_SLOT_X];
   assign sy      = group_in.slot[`MAD_SLOT_Y];
   assign chk_s64 = $signed(sx.src0) * $signed(sx.src1);
   assign chk_u64 = {32'h0, sx.src0} * {32'h0, sx.src1};
   assign chk_m24 = {40'h0, sx.src0[23:0]} * {40'h0, sx.src1[23:0]};
   assign x_unit  = group_valid_in && sx.src0 == `MAD_FP_ONE
                 && fp_zero(sx.src2) && !sx.second_word[`MAD_CLAMP_BIT]
                 && sx.src1[30:23] > 8'h01 && sx.src1[30:23] < 8'hfd;

   property p_u24;
      @(posedge clk_in) disable iff (rst_in)
      group_valid_in && op[0] == mad_pkg::MAD_OP_U24 |=>
         result_out.value[0] == 32'($past(chk_m24) + {32'h0, $past(sx.src2)});
   endproperty
   a_u24: assert property (p_u24) else $error("u24 madd wrong");

   property p_smul_hi;
      @(posedge clk_in) disable iff (rst_in)
      group_valid_in && op[0] == mad_pkg::MAD_OP_SMUL_HI |=>
         result_out.value[0] == $past(chk_s64[63:32]);
   endproperty
   a_smul_hi: assert property (p_smul_hi) else $error("smul hi");

   property p_umul_hi;
      @(posedge clk_in) disable iff (rst_in)
      group_valid_in && op[0] == mad_pkg::MAD_OP_UMUL_HI |=>
         result_out.value[0] == $past(chk_u64[63:32]);
   endproperty
   a_umul_hi: assert property (p_umul_hi) else $error("umul hi");

   property p_u24_hi;
      @(posedge clk_in) disable iff (rst_in)
      group_valid_in && op[0] == mad_pkg::MAD_OP_U24_HI |=>
         result_out.value[0] == {16'h0, $past(chk_m24[47:32])};
   endproperty
   a_u24_hi: assert property (p_u24_hi) else $error("u24 hi");

   property p_smul_lo;
      @(posedge clk_in) disable iff (rst_in)
      group_valid_in && sx.second_word[`MAD_FMT_HI:`MAD_FMT_LO] == 3'h0
      && sx.second_word[`MAD_OP2_HI:`MAD_OP2_LO] == `MAD_OP2_SMUL_LO |=>
         result_out.value[0] == $past(chk_s64[31:0]) && result_out.handled[0];
   endproperty
   a_smul_lo: assert property (p_smul_lo) else $error("smul lo");

   property p_double;
      @(posedge clk_in) disable iff (rst_in)
      x_unit && op[0] == mad_pkg::MAD_OP_DOUBLE |=>
         result_out.value[0][30:23] == $past(sx.src1[30:23]) + 8'h01
         && result_out.value[0][22:0] == $past(sx.src1[22:0]);
   endproperty
   a_double: assert property (p_double) else $error("double wrong");

   property p_quad;
      @(posedge clk_in) disable iff (rst_in)
      x_unit && op[0] == mad_pkg::MAD_OP_QUAD |=>
         result_out.value[0][30:23] == $past(sx.src1[30:23]) + 8'h02;
   endproperty
   a_quad: assert property (p_quad) else $error("quadruple wrong");

   property p_halve;
      @(posedge clk_in) disable iff (rst_in)
      x_unit && op[0] == mad_pkg::MAD_OP_HALVE |=>
         result_out.value[0][30:23] == $past(sx.src1[30:23]) - 8'h01;
   endproperty
   a_halve: assert property (p_halve) else $error("halve wrong");

   property p_ieee_zero;
      @(posedge clk_in) disable iff (rst_in)
      group_valid_in && op[0] == mad_pkg::MAD_OP_IEEE && fp_zero(sx.src0)
      && fp_inf(sx.src1) |=> fp_nan(result_out.value[0]);
   endproperty
   a_ieee_zero: assert property (p_ieee_zero) else $error("ieee zero");

   property p_forward;
      @(posedge clk_in) disable iff (rst_in)
      group_valid_in && op[1] == mad_pkg::MAD_OP_PREV_IEEE
      && fp_zero(sy.src0) && fp_zero(sy.src1) && !fp_zero(raw[`MAD_SLOT_W])
      && !fp_nan(raw[`MAD_SLOT_W]) && !sy.second_word[`MAD_CLAMP_BIT]
      && sy.second_word[`MAD_OUTPUT_SCALING_HI:`MAD_OUTPUT_SCALING_LO] == `MAD_OUTPUT_SCALING_NONE |=>
         result_out.value[1] == $past(raw[`MAD_SLOT_W]);
   endproperty
   a_forward: assert property (p_forward) else $error("forward wrong");

endmodule : mad_alu

/* File: verilog/mad_defs.svh */
// field positions, opcodes and float constants for the multiply-add alu
`ifndef MAD_DEFS_SVH
`define MAD_DEFS_SVH
`define MAD_FMT_HI        17
`define MAD_FMT_LO        15
`define MAD_OP3_HI        17
`define MAD_OP3_LO        13
`define MAD_OP2_HI        17
`define MAD_OP2_LO        7
`define MAD_OUTPUT_SCALING_HI       6
`define MAD_OUTPUT_SCALING_LO       5
`define MAD_CLAMP_BIT     31
`define MAD_OP3_U24       5'h10
`define MAD_OP3_DOUBLE    5'h15
`define MAD_OP3_QUAD      5'h16
`define MAD_OP3_HALVE     5'h17
`define MAD_OP3_IEEE      5'h18
`define MAD_OP2_SMUL_LO   11'h08f
`define MAD_OP2_SMUL_HI   11'h090
`define MAD_OP2_UMUL_HI   11'h092
`define MAD_OP2_U24_HI    11'h0b2
`define MAD_OP2_PREV      11'h0d4
`define MAD_OP2_PREV_IEEE 11'h0d5
`define MAD_OUTPUT_SCALING_NONE     2'h0
`define MAD_OUTPUT_SCALING_X2       2'h1
`define MAD_OUTPUT_SCALING_X4       2'h2
`define MAD_OUTPUT_SCALING_HALF     2'h3
`define MAD_FP_NAN        32'h7fc00000
`define MAD_FP_ONE        32'h3f800000
`define MAD_FP_EMAX       8'hff
`define MAD_FP_BIAS       10'h07f
`define MAD_FP_OVF        10'h17e
`define MAD_SLOT_X        2'h0
`define MAD_SLOT_Y        2'h1
`define MAD_SLOT_Z        2'h2
`define MAD_SLOT_W        2'h3
`endif

/* File: verilog/mad_pkg.sv */
// types shared by the multiply-add alu block
package mad_pkg;
   typedef enum logic [3:0] {
      MAD_OP_NONE      = 4'h0,
      MAD_OP_HALVE     = 4'h1,
      MAD_OP_IEEE      = 4'h2,
      MAD_OP_DOUBLE    = 4'h3,
      MAD_OP_QUAD      = 4'h4,
      MAD_OP_U24       = 4'h5,
      MAD_OP_PREV      = 4'h6,
      MAD_OP_PREV_IEEE = 4'h7,
      MAD_OP_SMUL_HI   = 4'h8,
      MAD_OP_UMUL_HI   = 4'h9,
      MAD_OP_U24_HI    = 4'ha,
      MAD_OP_SMUL_LO   = 4'hb
   } mad_op_e;

   typedef struct packed {
      logic [31:0] common_instr_word;
      logic [31:0] second_word;
      logic [31:0] src0;
      logic [31:0] src1;
      logic [31:0] src2;
   } mad_slot_s;

   // slot 0 is x, 1 is y, 2 is z, 3 is w
   typedef struct packed {
      mad_slot_s [3:0] slot;
   } mad_group_s;

   typedef struct packed {
      logic [3:0][31:0] value;
      logic [3:0]       handled;
      logic [3:0]       illegal;
   } mad_result_s;
endpackage : mad_pkg
